// ---- design/bit_branch_map.svh ----
`ifndef BIT_BRANCH_MAP_SVH
`define BIT_BRANCH_MAP_SVH
`define TOGGLE_TOP_NIBBLE 4'h7
`define BRANCH_TOP_NIBBLE 4'he
`define BRANCH_ZERO_SUB 4'h0
`define BRANCH_OVF_SUB 4'h4
`define LITERAL_OFFSET_LIMIT 8'h5f
`define INSTR_STEP 21'h00_0002
`define PC_RESET 21'h00_0000
`define FILE_ADDR_RESET 12'h000
`define DATA_RESET 8'h00
`endif

// ---- design/bit_branch_pkg.sv ----
package bit_branch_pkg;
  typedef enum logic [1:0] {quarter_one, quarter_two, quarter_three, quarter_four} quarter_t;
  typedef enum logic [1:0] {op_none, bit_invert_op, branch_on_zero_op, branch_on_ovf_op} op_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
    logic we;
    logic re;
    logic idx;
  } mem_req_t;
  typedef struct packed {
    logic zero;
    logic ovf;
  } flags_t;
endpackage

// ---- design/quarter_gen.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Quarter phase sequencer of one instruction cycle.
// ----------------------------------------
module quarter_gen
  import bit_branch_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  output quarter_t quarter_o
);
  quarter_t next_quarter;

  // Step through the four quarters in order and wrap.
  always_comb
  begin
    case (quarter_o)
      quarter_one: next_quarter = quarter_two;
      quarter_two: next_quarter = quarter_three;
      quarter_three: next_quarter = quarter_four;
      quarter_four: next_quarter = quarter_one;
      default: next_quarter = quarter_one;
    endcase
  end

  // Register the phase.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      quarter_o <= quarter_one;
    else
      quarter_o <= next_quarter;
  end
endmodule

// ---- design/bit_branch_exec.sv ----
`timescale 1ns/1ps
// Function
// - Toggle instruction 0111 bbba ffffffff inverts only selected bit of the byte.
// - Bank flag clear selects the fixed quick-access bank for the file address.
// - Bank flag set joins bank select register with file address.
// - Flag clear, extended set on, address at most 95 means indexed literal offset.
// - Branch-on-zero 1110 0000 jumps only when zero flag is one.
// - Branch-on-overflow 1110 0100 jumps only when overflow flag set.
// - Offset is signed eight bits, doubled, added to program counter.
// - Taken target is instruction address plus two plus twice offset.
// - Branch is one word; one cycle untaken, two taken with a no-op slot.
module bit_branch_exec
  import bit_branch_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] instr_i,
  input wire logic [20:0] instr_addr_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic ext_set_en_i,
  input wire flags_t flags_i,
  input wire logic [7:0] mem_rdata_i,
  output mem_req_t mem_o,
  output logic [20:0] pc_o,
  output logic pc_load_o,
  output logic flush_o,
  output logic cycle_end_o,
  output logic [1:0] quarter_o
);
`include "bit_branch_map.svh"

  quarter_t quarter;
  op_t op;
  logic [7:0] rdata;
  logic nop_slot;
  logic taken;
  logic [20:0] target;
  mem_req_t next_mem;
  logic [20:0] next_pc;
  logic next_pc_load;
  logic next_flush;
  logic next_nop_slot;
  logic [7:0] next_rdata;

  quarter_gen u_quarter
  (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .quarter_o(quarter)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Classify the word; a no-op slot suppresses decode of the flushed word.
  always_comb
  begin
    op = op_none;
    if (!nop_slot)
    begin
      if (instr_i[15:12] == `TOGGLE_TOP_NIBBLE)
        op = bit_invert_op;
      else if (instr_i[15:8] == {`BRANCH_TOP_NIBBLE, `BRANCH_ZERO_SUB})
        op = branch_on_zero_op;
      else if (instr_i[15:8] == {`BRANCH_TOP_NIBBLE, `BRANCH_OVF_SUB})
        op = branch_on_ovf_op;
    end
  end

  // Branch condition and target; the fetch address plus one step plus twice the offset.
  always_comb
  begin
    taken = ((op == branch_on_zero_op) && flags_i.zero)
      || ((op == branch_on_ovf_op) && flags_i.ovf);
    target = instr_addr_i + `INSTR_STEP
      + {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
  end

  // ----------------------------------------
  // Execute per quarter
  // ----------------------------------------
  // Flags are never driven from here, so all three leave the status untouched.
  always_comb
  begin
    next_mem = mem_o;
    next_mem.we = 1'b0;
    next_mem.re = 1'b0;
    next_pc = pc_o;
    next_pc_load = 1'b0;
    next_flush = flush_o;
    next_nop_slot = nop_slot;
    next_rdata = rdata;
    case (quarter)
      quarter_one:
      begin
        // Address resolves a quarter ahead so the read lands in the second quarter.
        if (op == bit_invert_op)
        begin
          next_mem.re = 1'b1;
          next_mem.idx = 1'b0;
          if (instr_i[8])
            next_mem.addr = {bank_select_reg_i, instr_i[7:0]};
          else if (ext_set_en_i && (instr_i[7:0] <= `LITERAL_OFFSET_LIMIT))
          begin
            next_mem.addr = {4'h0, instr_i[7:0]};
            next_mem.idx = 1'b1;
          end
          else if (instr_i[7])
            next_mem.addr = {4'hf, instr_i[7:0]};
          else
            next_mem.addr = {4'h0, instr_i[7:0]};
        end
      end
      quarter_two:
        next_rdata = mem_rdata_i;
      quarter_three:
      begin
        if (op == bit_invert_op)
        begin
          next_mem.data = rdata ^ (8'h01 << instr_i[11:9]);
          next_mem.we = 1'b1;
        end
      end
      quarter_four:
      begin
        // A taken branch writes the counter here and burns the next cycle.
        next_nop_slot = taken;
        next_flush = taken;
        if (taken)
        begin
          next_pc = target;
          next_pc_load = 1'b1;
        end
      end
      default: next_rdata = rdata;
    endcase
  end

  // Register state and outputs.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mem_o <= '{addr: `FILE_ADDR_RESET, data: `DATA_RESET, we: 1'b0, re: 1'b0, idx: 1'b0};
      pc_o <= `PC_RESET;
      pc_load_o <= 1'b0;
      flush_o <= 1'b0;
      nop_slot <= 1'b0;
      rdata <= `DATA_RESET;
      cycle_end_o <= 1'b0;
      quarter_o <= 2'b00;
    end
    else
    begin
      mem_o <= next_mem;
      pc_o <= next_pc;
      pc_load_o <= next_pc_load;
      flush_o <= next_flush;
      nop_slot <= next_nop_slot;
      rdata <= next_rdata;
      cycle_end_o <= (quarter == quarter_four);
      quarter_o <= quarter;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_toggle_write;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (quarter == quarter_three && op == bit_invert_op)
    |=> (mem_o.we && ((mem_o.data ^ rdata) == (8'h01 << $past(instr_i[11:9]))));
  endproperty
  a_toggle_write: assert property (p_toggle_write) else $error("toggle wrong bit");

  property p_bank_flag;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (quarter == quarter_one && op == bit_invert_op && instr_i[8])
    |=> (mem_o.addr == {$past(bank_select_reg_i), $past(instr_i[7:0])});
  endproperty
  a_bank_flag: assert property (p_bank_flag) else $error("banked address wrong");

  property p_access_bank;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (quarter == quarter_one && op == bit_invert_op && !instr_i[8] && !ext_set_en_i)
    |=> (!mem_o.idx && mem_o.addr[7:0] == $past(instr_i[7:0]));
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

  property p_literal;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (quarter == quarter_one && op == bit_invert_op && !instr_i[8] && ext_set_en_i
      && instr_i[7:0] <= `LITERAL_OFFSET_LIMIT) |=> mem_o.idx;
  endproperty
  a_literal: assert property (p_literal) else $error("literal offset missed");

  property p_zero_branch;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (quarter == quarter_four && op == branch_on_zero_op) |=> (pc_load_o == $past(flags_i.zero));
  endproperty
  a_zero_branch: assert property (p_zero_branch) else $error("zero branch wrong");

  property p_ovf_branch;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (quarter == quarter_four && op == branch_on_ovf_op) |=> (pc_load_o == $past(flags_i.ovf));
  endproperty
  a_ovf_branch: assert property (p_ovf_branch) else $error("overflow branch wrong");

  property p_target;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (quarter == quarter_four && taken)
    |=> (pc_o == $past(instr_addr_i) + `INSTR_STEP
      + (21'($signed($past(instr_i[7:0]))) << 1));
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_offset;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    1'b1 |-> (target - instr_addr_i - `INSTR_STEP)
      == 21'({{13{instr_i[7]}}, instr_i[7:0]} << 1);
  endproperty
  a_offset: assert property (p_offset) else $error("offset scaling wrong");

  property p_nop_slot;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    pc_load_o |-> (nop_slot && op == op_none)[*4];
  endproperty
  a_nop_slot: assert property (p_nop_slot) else $error("no-op slot missing");

  property p_write_quarter;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    mem_o.we |-> (quarter == quarter_four);
  endproperty
  a_write_quarter: assert property (p_write_quarter) else $error("write outside cycle");
endmodule

// ---- sim/data_mem_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Data memory on the far side of the executor.
// ----------------------------------------
module data_mem_model
  import bit_branch_pkg::*;
(
  input wire logic sys_clk_i,
  input wire mem_req_t mem_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] store [4096];
  logic [7:0] last = 8'h00;
  // Same fill pattern as the bench so both start from one picture.
  initial
  begin
    for (int i = 0; i < 4096; i++) store[i] = i[7:0] ^ 8'h5a;
  end
  // Off the strobe the bus shows the inverse of the last byte, so a late sample fails.
  always_comb mem_rdata_o = mem_i.re ? store[mem_i.addr] : ~last;
  // Writes land on the edge that ends the write strobe.
  always @(posedge sys_clk_i)
  begin
    if (mem_i.re) last <= store[mem_i.addr];
    if (mem_i.we) store[mem_i.addr] <= mem_i.data;
  end
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the bit invert and flag branch executor.
// ----------------------------------------
module tb_top;
  import bit_branch_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [20:0] instr_addr_i = 21'h00_0000;
  logic [3:0] bank_select_reg_i = 4'h0;
  logic ext_set_en_i = 1'b0;
  flags_t flags_i = '0;
  logic [7:0] mem_rdata_i;
  mem_req_t mem_o;
  logic [20:0] pc_o;
  logic pc_load_o, flush_o, cycle_end_o;
  logic [1:0] quarter_o;
  int error_cnt = 0;
  int tests_run = 0;
  int q_addr[$], q_bit[$], q_pc[$];
  int ma, mb;
  logic [7:0] md;
  logic [7:0] model [4096];
  bit flush_pend = 0;
  bit tog_now = 0;
  int cyc = 0;

  bit_branch_exec i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .instr_i(instr_i),
    .instr_addr_i(instr_addr_i), .bank_select_reg_i(bank_select_reg_i),
    .ext_set_en_i(ext_set_en_i), .flags_i(flags_i), .mem_rdata_i(mem_rdata_i), .mem_o(mem_o),
    .pc_o(pc_o), .pc_load_o(pc_load_o), .flush_o(flush_o), .cycle_end_o(cycle_end_o),
    .quarter_o(quarter_o));
  data_mem_model i_mem (.sys_clk_i(sys_clk_i), .mem_i(mem_o), .mem_rdata_o(mem_rdata_i));

  // Free running 100 MHz clock.
  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] exp_v, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp_v)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", name, exp_v, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Presents one word for a whole cycle and queues what the model expects from it.
  task automatic issue(input logic [15:0] w, input logic [20:0] pa);
    logic [7:0] f;
    f = w[7:0];
    tog_now = 0;
    instr_i = w;
    instr_addr_i = pa;
    if (flush_pend)
    begin
      flush_pend = 0;
      repeat (2) @(posedge sys_clk_i);
      #2;
      check("flush", 1, flush_o);
      repeat (2) @(posedge sys_clk_i);
      #1;
      return;
    end
    if (w[15:12] == 4'h7)
    begin
      tog_now = 1;
      q_bit.push_back(w[11:9]);
      if (!w[8] && ext_set_en_i && f <= 8'h5f) q_addr.push_back(4096 + f);
      else if (w[8]) q_addr.push_back({bank_select_reg_i, f});
      else q_addr.push_back(f < 8'h80 ? {4'h0, f} : {4'hf, f});
    end
    else if ((w[15:8] == 8'he0 && flags_i.zero) || (w[15:8] == 8'he4 && flags_i.ovf))
    begin
      q_pc.push_back((pa + 2 + 2 * int'($signed(f))) & 32'h001f_ffff);
      flush_pend = 1;
    end
    repeat (4) @(posedge sys_clk_i);
    #1;
    check("flush level", flush_pend, flush_o);
  endtask

  // ----------------------------------------
  // Result monitor: every write and every load is compared at once.
  // ----------------------------------------
  always
  begin
    @(posedge sys_clk_i);
    #2;
    // Phase outputs lag the internal quarter by one clock, counted from reset release.
    if (rst_b_i === 1'b1)
    begin
      if (cyc > 0)
      begin
        check("phase", (cyc - 1) % 4, quarter_o);
        check("cycle end", cyc % 4 == 0, cycle_end_o);
      end
      check("read strobe", (cyc % 4 == 1) && tog_now, mem_o.re);
      cyc++;
    end
    if (mem_o.we === 1'b1)
    begin
      if (q_addr.size() == 0) check("stray write", 0, 1);
      else
      begin
        ma = q_addr.pop_front();
        mb = q_bit.pop_front();
        check("indexed", ma >= 4096, mem_o.idx);
        if (ma >= 4096) check("offset", ma - 4096, mem_o.addr[7:0]);
        else check("address", ma, mem_o.addr);
        md = model[mem_o.addr] ^ (8'h01 << mb);
        check("data", md, mem_o.data);
        model[mem_o.addr] = md;
      end
    end
    if (pc_load_o === 1'b1)
    begin
      if (q_pc.size() == 0) check("stray load", 0, 1);
      else check("target", q_pc.pop_front(), pc_o);
    end
  end

  // Watchdog, about twenty times the expected run length.
  initial
  begin
    #50000;
    error_cnt++;
    $display("unexpected timeout");
    finish_test();
  end

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial
  begin
    void'($urandom(27930));
    for (int i = 0; i < 4096; i++) model[i] = i[7:0] ^ 8'h5a;
    repeat (3) @(posedge sys_clk_i);
    #1;
    rst_b_i = 1'b1;
    // Every bit of one byte, back to back, so read-after-write hazards show.
    for (int i = 0; i < 8; i++) issue({4'h7, i[2:0], 1'b0, 8'h80}, 21'h00_0100);
    ext_set_en_i = 1'b1;
    issue(16'h7e5f, 21'h00_0102);
    issue(16'h7e60, 21'h00_0104);
    ext_set_en_i = 1'b0;
    issue(16'h7e5f, 21'h00_0106);
    bank_select_reg_i = 4'h3;
    issue(16'h7b12, 21'h00_0108);
    // Zero branch at offset -128 and overflow branch at +127 under each flag pair; the word after a taken branch is the no-op slot.
    for (int k = 0; k < 4; k++)
    begin
      flags_i = k[1:0];
      issue(16'he080, 21'h00_0200);
      issue(16'he47f, 21'h1f_fff0);
    end
    for (int i = 0; i < 40; i++)
    begin
      bank_select_reg_i = 4'($urandom);
      ext_set_en_i = 1'($urandom);
      flags_i = 2'($urandom);
      case ($urandom % 3)
        0: issue({4'h7, 12'($urandom)}, 21'($urandom) & 21'h1f_fffe);
        1: issue({8'he0, 8'($urandom)}, 21'($urandom) & 21'h1f_fffe);
        default: issue({8'he4, 8'($urandom)}, 21'($urandom) & 21'h1f_fffe);
      endcase
    end
    // A neutral word stops the last instruction from running again while the bench drains.
    issue(16'h0000, 21'h00_0000);
    repeat (8) @(posedge sys_clk_i);
    check("pending", 0, q_addr.size() + q_pc.size());
    finish_test();
  end
endmodule
